// file: hdl/uart_pkg.sv
// Function
// - Four modes chosen by control register; mode 1 after reset.
// - Mode 0: device masters shift clock on transmit pin, data on receive pin.
// - Mode 0 shift clock is system clock over 12 or 4, by multiproc bit.
// - Mode 1 frame: start low, eight data LSB first, stop high.
// - Transmit starts shortly after the next baud tick following a buffer write.
// - Transmit-complete flag set two cycles after stop bit driven.
// - Reception starts on falling edge only with receive enable and baud running.
// - At mid stop, accept if receive flag clear and stop valid under multiproc.
// - On accept load buffer, ninth bit flag, set receive flag; else discard.
// - After mid stop, return to hunting for a falling edge.
// - Sample ticks 7, 8, 9 of sixteen; majority of three decides.
// - Invalid start bit abandons frame, hunt resumes.
// - Modes 2 and 3: eleven bit frame with programmable ninth bit.
// - Mode 2 rate fixed from system clock; mode 3 uses the generator.
// - Generator adds 16-bit phase into 17-bit accumulator; carry is baud tick.
// - Baud tick is sixteen times the bit rate, used for oversampling.
// - Accumulator trigger divided by 4 when baud select is 0.
// - Mode 2 bit rate is system clock over 32 or 64 by baud select.
// - Interrupt from receive or transmit flag only when enabled.
package uart_pkg;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_BUF = 3'h1;
    localparam logic [2:0] ADDR_MODE = 3'h2;
    localparam logic [2:0] ADDR_PHASE = 3'h3;
    // Control register fields
    localparam int CTRL_RX_FLAG = 0;
    localparam int CTRL_TX_FLAG = 1;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_MULTIPROC = 5;
    localparam int CTRL_MODE_LO = 6;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    // Mode register fields
    localparam int MODE_BAUD_SEL = 1;
    localparam int MODE_IRQ_EN = 2;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_ASYNC10 = 2'h1;
    localparam logic [1:0] MODE_FIXED11 = 2'h2;
    localparam logic [1:0] MODE_PROG11 = 2'h3;
    localparam logic [3:0] SHIFT_DIV_SLOW = 4'hb;
    localparam logic [3:0] SHIFT_DIV_FAST = 4'h3;
    localparam logic [1:0] TRIG_DIV = 2'h3;
    localparam logic [1:0] FIXED_DIV_FAST = 2'h1;
    localparam logic [1:0] FIXED_DIV_SLOW = 2'h3;
    localparam logic [3:0] SAMPLE_A = 4'h6;
    localparam logic [3:0] SAMPLE_C = 4'h8;
    localparam logic [1:0] TX_FLAG_DELAY = 2'h2;
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;
endpackage

// file: hdl/tick_if.sv
`timescale 1ns/1ns
`default_nettype none
// Oversampling tick shared by transmitter and receiver
interface tick_if;
    logic tick16;
    logic running;
    modport gen (output tick16, output running);
    modport use_ (input tick16, input running);
endinterface
`default_nettype wire

// file: hdl/baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
module baud_gen
    import uart_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [1:0] i_mode,
    input wire logic i_baud_sel,
    input wire logic [15:0] i_phase,
    tick_if.gen o_tick
);
    logic [16:0] acc_ff;
    logic [1:0] trig_ff;
    logic [1:0] fix_ff;
    logic trig;
    logic [17:0] nxt_acc;
    logic carry_ff;
    logic fixed_ff;
    assign trig = i_baud_sel | (trig_ff == TRIG_DIV);
    // Full 17-bit accumulator; only the overflow past it is a tick
    assign nxt_acc = {1'b0, acc_ff} + {2'b00, i_phase};
    always_ff @(posedge i_clk) begin
        if (i_srst) trig_ff <= 2'h0;
        else trig_ff <= trig_ff + 2'h1;
    end
    // Phase accumulation, carry out is tick
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            acc_ff <= 17'h0;
            carry_ff <= 1'b0;
        end else begin
            carry_ff <= trig & nxt_acc[17];
            if (trig) acc_ff <= nxt_acc[16:0];
        end
    end
    // Fixed rate: 16 ticks per bit over 32 or 64 clocks
    always_ff @(posedge i_clk) begin
        if (i_srst || fixed_ff) fix_ff <= 2'h0;
        else fix_ff <= fix_ff + 2'h1;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) fixed_ff <= 1'b0;
        else fixed_ff <= !fixed_ff && (fix_ff == (i_baud_sel ? FIXED_DIV_FAST : FIXED_DIV_SLOW) - 2'h1);
    end
    // Mode 2 fixed, modes 1 and 3 programmable
    assign o_tick.tick16 = (i_mode == MODE_FIXED11) ? fixed_ff : carry_ff;
    assign o_tick.running = (i_mode == MODE_FIXED11) | (i_phase != 16'h0);
endmodule // baud_gen
`default_nettype wire

// file: hdl/serial_port_uart.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module serial_port_uart
    import uart_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output logic O_TXD,
    input wire logic I_RXD,
    output logic O_RXD,
    output logic O_RXD_OE,
    output logic O_IRQ
);
    tick_if tk ();
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [15:0] phase_ff;
    logic [7:0] rx_buf_ff;
    logic [7:0] rdata_ff;
    logic [1:0] mode;
    logic wr_buf;
    // Transmit side
    logic tx_busy_ff;
    logic tx_pend_ff;
    logic [3:0] tx_tick_ff;
    logic [3:0] tx_bit_ff;
    logic [10:0] tx_shift_ff;
    logic txd_ff;
    logic [1:0] tx_done_ff;
    logic tx_set;
    logic [7:0] rx_buf_tx_ff;
    // Receive side
    rx_state_t rx_state_ff;
    logic [3:0] rx_tick_ff;
    logic [3:0] rx_bit_ff;
    logic [8:0] rx_shift_ff;
    logic [2:0] vote_ff;
    logic rxd_q_ff;
    logic rx_set;
    logic rx_accept;
    logic rx_bit;
    // Mode 0 shifter
    logic [3:0] sdiv_ff;
    logic sclk_ff;
    logic [3:0] s_cnt_ff;
    logic s_busy_ff;
    logic s_is_rx_ff;
    logic [7:0] s_shift_ff;
    logic s_done;
    logic s_clr_ff;
    logic s_data_oe_ff;

    function automatic logic majority(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    // Bit index of the stop bit: 10-bit frame in mode 1, 11-bit otherwise
    function automatic logic [3:0] frame_last(input logic [1:0] m);
        return (m == MODE_ASYNC10) ? 4'h9 : 4'ha;
    endfunction

    baud_gen u_baud (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_mode(mode),
        .i_baud_sel(mode_ff[MODE_BAUD_SEL]),
        .i_phase(phase_ff),
        .o_tick(tk)
    );

    assign mode = ctrl_ff[CTRL_MODE_LO+1:CTRL_MODE_LO];
    assign wr_buf = I_WR && (I_ADDR == ADDR_BUF);

    // Control register; hardware set wins over software write
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ctrl_ff <= CTRL_RESET;
        end else begin
            if (I_WR && I_ADDR == ADDR_CTRL) ctrl_ff <= I_WDATA;
            if (tx_set) ctrl_ff[CTRL_TX_FLAG] <= 1'b1;
            if (rx_set) ctrl_ff[CTRL_RX_FLAG] <= 1'b1;
            // Ninth bit captured on accept
            // Mode 1 keeps the voted stop bit, modes 2 and 3 the ninth bit
            if (rx_accept) ctrl_ff[CTRL_RX_NINTH] <= (mode == MODE_ASYNC10) ? rx_bit : rx_shift_ff[8];
        end
    end

    // Mode and phase registers
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            mode_ff <= MODE_RESET;
            phase_ff <= PHASE_RESET;
        end else if (I_WR) begin
            if (I_ADDR == ADDR_MODE) mode_ff <= I_WDATA & 8'h06;
            if (I_ADDR == ADDR_PHASE) phase_ff[7:0] <= I_WDATA;
            if (I_ADDR == ADDR_PHASE + 3'h1) phase_ff[15:8] <= I_WDATA;
        end
    end

    // Read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge I_CLK) begin
        if (I_SRST) rdata_ff <= 8'h00;
        else if (I_RD) begin
            unique case (I_ADDR)
                ADDR_CTRL: rdata_ff <= ctrl_ff;
                ADDR_BUF: rdata_ff <= rx_buf_ff;
                ADDR_MODE: rdata_ff <= mode_ff;
                ADDR_PHASE: rdata_ff <= phase_ff[7:0];
                ADDR_PHASE + 3'h1: rdata_ff <= phase_ff[15:8];
                default: rdata_ff <= 8'h00;
            endcase
        end else rdata_ff <= 8'h00;
    end
    assign O_RDATA = rdata_ff;

    assign O_IRQ = mode_ff[MODE_IRQ_EN] & (ctrl_ff[CTRL_RX_FLAG] | ctrl_ff[CTRL_TX_FLAG]);

    // Wait for next baud tick after buffer write
    always_ff @(posedge I_CLK) begin
        if (I_SRST) tx_pend_ff <= 1'b0;
        else if (wr_buf && mode != MODE_SHIFT) tx_pend_ff <= 1'b1;
        else if (tk.tick16) tx_pend_ff <= 1'b0;
    end

    // Frame shifter, LSB first, start low, stop high
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            tx_busy_ff <= 1'b0;
            tx_tick_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            tx_shift_ff <= 11'h7ff;
            txd_ff <= 1'b1;
        end else if (!tx_busy_ff) begin
            txd_ff <= 1'b1;
            if (tx_pend_ff && tk.tick16) begin
                tx_busy_ff <= 1'b1;
                tx_tick_ff <= 4'h0;
                tx_bit_ff <= 4'h0;
                tx_shift_ff <= (mode == MODE_ASYNC10) ? {2'b11, rx_buf_tx_ff, 1'b0}
                    : {1'b1, ctrl_ff[CTRL_TX_NINTH], rx_buf_tx_ff, 1'b0};
                txd_ff <= 1'b0;
            end
        end else if (tk.tick16) begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_bit_ff <= tx_bit_ff + 4'h1;
                txd_ff <= tx_shift_ff[1];
                if (tx_bit_ff == frame_last(mode)) begin
                    tx_busy_ff <= 1'b0;
                    txd_ff <= 1'b1;
                end
            end
        end
    end

    // Transmit byte held separately from the receive buffer
    always_ff @(posedge I_CLK) begin
        if (I_SRST) rx_buf_tx_ff <= 8'h00;
        else if (wr_buf) rx_buf_tx_ff <= I_WDATA;
    end

    // Flag two cycles after stop bit placed
    // Armed on the very edge that puts the stop bit on the pin
    always_ff @(posedge I_CLK) begin
        if (I_SRST) tx_done_ff <= 2'h0;
        else if (tx_busy_ff && tk.tick16 && tx_tick_ff == 4'hf
                 && tx_bit_ff == frame_last(mode) - 4'h1) tx_done_ff <= TX_FLAG_DELAY;
        else if (tx_done_ff != 2'h0) tx_done_ff <= tx_done_ff - 2'h1;
    end
    assign tx_set = (tx_done_ff == 2'h1) | (s_done & ~s_is_rx_ff);

    // Receive line history for edge detection
    always_ff @(posedge I_CLK) begin
        if (I_SRST) rxd_q_ff <= 1'b1;
        else rxd_q_ff <= I_RXD;
    end

    assign rx_bit = majority(vote_ff);
    always_ff @(posedge I_CLK) begin
        if (I_SRST) vote_ff <= 3'h7;
        else if (tk.tick16 && rx_tick_ff >= SAMPLE_A && rx_tick_ff <= SAMPLE_C)
            vote_ff <= {vote_ff[1:0], I_RXD};
    end

    assign rx_accept = (rx_state_ff == RX_STOP) && tk.tick16 && (rx_tick_ff == SAMPLE_C + 4'h1)
        && !ctrl_ff[CTRL_RX_FLAG] && (!ctrl_ff[CTRL_MULTIPROC] || rx_bit);
    assign rx_set = rx_accept | (s_done & s_is_rx_ff);

    // Receiver state machine
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rx_state_ff <= RX_IDLE;
            rx_tick_ff <= 4'h0;
            rx_bit_ff <= 4'h0;
            rx_shift_ff <= 9'h000;
        end else begin
            unique case (rx_state_ff)
                RX_IDLE: begin
                    rx_tick_ff <= 4'h0;
                    rx_bit_ff <= 4'h0;
                    // Falling edge with enable and generator running
                    if (mode != MODE_SHIFT && ctrl_ff[CTRL_RX_EN] && tk.running && rxd_q_ff && !I_RXD)
                        rx_state_ff <= RX_START;
                end
                RX_START: if (tk.tick16) begin
                    rx_tick_ff <= rx_tick_ff + 4'h1;
                    if (rx_tick_ff == SAMPLE_C + 4'h1 && rx_bit) rx_state_ff <= RX_IDLE;
                    if (rx_tick_ff == 4'hf) rx_state_ff <= RX_DATA;
                end
                RX_DATA: if (tk.tick16) begin
                    rx_tick_ff <= rx_tick_ff + 4'h1;
                    if (rx_tick_ff == SAMPLE_C + 4'h1) begin
                        rx_shift_ff <= {rx_bit, rx_shift_ff[8:1]};
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                    end
                    if (rx_tick_ff == 4'hf && rx_bit_ff == frame_last(mode) - 4'h1)
                        rx_state_ff <= RX_STOP;
                end
                RX_STOP: if (tk.tick16) begin
                    rx_tick_ff <= rx_tick_ff + 4'h1;
                    // Back to hunting after mid stop
                    if (rx_tick_ff == SAMPLE_C + 4'h1) rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Buffer load on accept; mode 0 receive too
    always_ff @(posedge I_CLK) begin
        if (I_SRST) rx_buf_ff <= 8'h00;
        else if (rx_accept && mode == MODE_ASYNC10) rx_buf_ff <= rx_shift_ff[8:1];
        else if (rx_accept) rx_buf_ff <= rx_shift_ff[7:0];
        else if (s_done && s_is_rx_ff) rx_buf_ff <= s_shift_ff;
    end

    // Shift clock divider, 12 or 4
    always_ff @(posedge I_CLK) begin
        if (I_SRST || !s_busy_ff) sdiv_ff <= 4'h0;
        else if (sdiv_ff == (ctrl_ff[CTRL_MULTIPROC] ? SHIFT_DIV_FAST : SHIFT_DIV_SLOW)) sdiv_ff <= 4'h0;
        else sdiv_ff <= sdiv_ff + 4'h1;
    end

    // Mode 0 master shifter, eight bits LSB first
    assign s_done = s_busy_ff && s_cnt_ff == SHIFT_BITS;
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            s_busy_ff <= 1'b0;
            s_is_rx_ff <= 1'b0;
            s_cnt_ff <= 4'h0;
            s_shift_ff <= 8'h00;
            sclk_ff <= 1'b1;
            s_data_oe_ff <= 1'b0;
            s_clr_ff <= 1'b0;
        end else begin
            s_clr_ff <= ctrl_ff[CTRL_RX_FLAG];
            if (!s_busy_ff) begin
                sclk_ff <= 1'b1;
                s_cnt_ff <= 4'h0;
                s_data_oe_ff <= 1'b0;
                if (mode == MODE_SHIFT && wr_buf) begin
                    s_busy_ff <= 1'b1;
                    s_is_rx_ff <= 1'b0;
                    s_shift_ff <= I_WDATA;
                    s_data_oe_ff <= 1'b1;
                end else if (mode == MODE_SHIFT && ctrl_ff[CTRL_RX_EN] && !ctrl_ff[CTRL_RX_FLAG] && !s_clr_ff) begin
                    s_busy_ff <= 1'b1;
                    s_is_rx_ff <= 1'b1;
                end
            end else if (s_done) begin
                s_busy_ff <= 1'b0;
                s_data_oe_ff <= 1'b0;
            end else if (sdiv_ff == 4'h1) begin
                sclk_ff <= 1'b0;
            end else if (sdiv_ff == 4'h0 && !sclk_ff) begin
                // Rising shift clock: data sampled and advanced
                sclk_ff <= 1'b1;
                s_shift_ff <= {s_is_rx_ff ? I_RXD : 1'b1, s_shift_ff[7:1]};
                s_cnt_ff <= s_cnt_ff + 4'h1;
            end
        end
    end

    // Pins: mode 0 puts shift clock on transmit line
    assign O_TXD = (mode == MODE_SHIFT) ? sclk_ff : txd_ff;
    assign O_RXD = s_shift_ff[0];
    assign O_RXD_OE = (mode == MODE_SHIFT) & s_data_oe_ff & ~s_is_rx_ff;
endmodule // serial_port_uart
`default_nettype wire

// file: test/serial_port_uart_properties.sv
`timescale 1ns/1ns
`default_nettype none
module serial_port_uart_properties
    import uart_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic O_TXD,
    input wire logic I_RXD,
    input wire logic O_RXD,
    input wire logic O_RXD_OE,
    input wire logic O_IRQ
);
    logic [1:0] mode_ff;
    logic [7:0] mreg_ff;
    logic [15:0] phase_ff;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    // Shadows of software-owned fields; hardware never rewrites them
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            mode_ff <= CTRL_RESET[7:6];
            mreg_ff <= MODE_RESET;
            phase_ff <= PHASE_RESET;
        end else if (I_WR) begin
            if (I_ADDR == ADDR_CTRL) mode_ff <= I_WDATA[7:6];
            if (I_ADDR == ADDR_MODE) mreg_ff <= I_WDATA & 8'h06;
            if (I_ADDR == ADDR_PHASE) phase_ff[7:0] <= I_WDATA;
            if (I_ADDR == ADDR_PHASE + 3'h1) phase_ff[15:8] <= I_WDATA;
        end
    end

    a_reset_idle: assert property (
        $fell(I_SRST) |-> O_TXD && !O_RXD_OE && !O_IRQ && O_RDATA == 8'h00)
        else $error("Outputs not idle after reset");
    a_drive_shift_only: assert property (O_RXD_OE |-> mode_ff == MODE_SHIFT)
        else $error("Data pin driven outside shift mode");
    a_start_bit_held: assert property (
        $fell(O_TXD) && mode_ff != MODE_SHIFT |-> (!O_TXD) [*8])
        else $error("Start bit shorter than eight cycles");
    a_txd_waits_tick: assert property (
        mode_ff == MODE_ASYNC10 && phase_ff == 16'h0000 && O_TXD |=> O_TXD)
        else $error("Transmit began with generator stopped");
    a_irq_masked: assert property (!mreg_ff[MODE_IRQ_EN] |-> !O_IRQ)
        else $error("Interrupt raised while disabled");
    a_irq_clears: assert property (
        mreg_ff[MODE_IRQ_EN] && I_WR && I_ADDR == ADDR_CTRL && I_WDATA[1:0] == 2'h0 |=> !O_IRQ)
        else $error("Interrupt stayed after flags cleared");
    a_phase_readback: assert property (
        I_RD && I_ADDR == ADDR_PHASE |=> O_RDATA == phase_ff[7:0])
        else $error("Phase low byte read back wrong");
    a_mode_readback: assert property (
        I_RD && I_ADDR == ADDR_MODE |=> O_RDATA == mreg_ff)
        else $error("Mode register read back wrong");
endmodule // serial_port_uart_properties

bind serial_port_uart serial_port_uart_properties checker_i (
    .I_CLK(I_CLK), .I_SRST(I_SRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_TXD(O_TXD), .I_RXD(I_RXD), .O_RXD(O_RXD), .O_RXD_OE(O_RXD_OE), .O_IRQ(O_IRQ)
);
`default_nettype wire

// file: test/remote_serial.sv
`timescale 1ns/1ns
`default_nettype none
module remote_serial (
    input wire logic clk,
    input wire logic txd,
    input wire logic dev_data,
    input wire logic dev_oe,
    output logic line
);
    logic drive_ff = 1'b1;

    // Device owns the data line only while its driver is enabled
    assign line = (dev_oe === 1'b1) ? dev_data : drive_ff;

    task automatic send(input logic [10:0] frame, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            drive_ff <= frame[i];
            repeat (per) @(posedge clk);
        end
        drive_ff <= 1'b1;
        repeat (64) @(posedge clk);
    endtask

    task automatic catch_async(input int n, input int per, output logic [10:0] got, output bit ok);
        int t;
        got = 11'h000;
        t = 0;
        while (txd !== 1'b0 && t < 5000) begin
            @(posedge clk);
            #1;
            t++;
        end
        ok = t < 5000;
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            #1;
            got[i] = txd;
            repeat (per) @(posedge clk);
        end
    endtask

    // data taken on rising shift clock, as it stood just before the edge
    task automatic catch_shift(output logic [7:0] got, output int per, output bit ok);
        int t;
        int k;
        logic prev;
        logic prev_line;
        t = 0;
        k = 0;
        prev = txd;
        prev_line = line;
        while (k < 8 && t < 2000) begin
            @(posedge clk);
            #1;
            t++;
            if (txd && !prev) begin
                got[k] = prev_line;
                if (k == 1) per = t - per;
                if (k == 0) per = t;
                k++;
            end
            prev = txd;
            prev_line = line;
        end
        ok = k == 8;
        repeat (16) @(posedge clk);
    endtask

    // data placed after each falling shift clock, LSB first
    task automatic feed_shift(input logic [7:0] data, output bit ok);
        int t;
        int k;
        logic prev;
        t = 0;
        k = 0;
        prev = txd;
        while (k < 8 && t < 2000) begin
            @(posedge clk);
            #1;
            t++;
            if (!txd && prev) begin
                drive_ff <= data[k];
                k++;
            end
            prev = txd;
        end
        ok = k == 8;
        repeat (16) @(posedge clk);
        drive_ff <= 1'b1;
    endtask
endmodule // remote_serial
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import uart_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic irq;
    wire logic line;
    int fail_count = 0;
    int checks = 0;
    logic [10:0] got;
    logic [7:0] sh;
    int per;
    bit ok;

    serial_port_uart DUT (
        .I_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_TXD(txd), .I_RXD(line), .O_RXD(rxd_out), .O_RXD_OE(rxd_oe), .O_IRQ(irq)
    );
    remote_serial far_end (.clk(clk), .txd(txd), .dev_data(rxd_out), .dev_oe(rxd_oe), .line(line));

    // System clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    // A far-end wait that ran out ends the run at once
    task automatic guard();
        if (!ok) begin
            fail_count++;
            close_out();
        end
    endtask

    // One-cycle strobe, then a quiet edge so strobes never collide
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(name, {3'h0, rdata}, {3'h0, exp});
        @(posedge clk);
    endtask

    task automatic frame_chk(input string name, input int n, input int p, input logic [10:0] exp);
        far_end.catch_async(n, p, got, ok);
        guard();
        chk(name, got, exp);
    endtask

    task automatic shift_chk(input logic [7:0] exp, input int p);
        far_end.catch_shift(sh, per, ok);
        guard();
        chk("shift data", {3'h0, sh}, {3'h0, exp});
        chk("shift period", per[10:0], p[10:0]);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk("control", ADDR_CTRL, CTRL_RESET);
        rd_chk("mode reg", ADDR_MODE, MODE_RESET);
        rd_chk("phase", ADDR_PHASE, PHASE_RESET[7:0]);
        rd_chk("unmapped", 3'h7, 8'h00);
        // tick every 4 cycles, 64 cycles a bit
        wr_reg(ADDR_PHASE, 8'h00);
        wr_reg(ADDR_PHASE + 3'h1, 8'h80);
        wr_reg(ADDR_MODE, 8'h02);
        // mode 1 transmit and interrupt gating
        wr_reg(ADDR_BUF, 8'ha5);
        frame_chk("mode1 frame", 10, 64, 11'h34a);
        rd_chk("tx flag", ADDR_CTRL, 8'h42);
        chk("irq masked", {10'h0, irq}, 11'h000);
        wr_reg(ADDR_MODE, 8'h06);
        chk("irq raised", {10'h0, irq}, 11'h001);
        wr_reg(ADDR_CTRL, 8'h50);
        chk("irq cleared", {10'h0, irq}, 11'h000);
        far_end.send(11'h278, 10, 64);
        rd_chk("rx byte", ADDR_BUF, 8'h3c);
        rd_chk("rx flags", ADDR_CTRL, 8'h55);
        // full flag or bad stop drops the byte
        far_end.send(11'h386, 10, 64);
        rd_chk("kept byte", ADDR_BUF, 8'h3c);
        wr_reg(ADDR_CTRL, 8'h70);
        far_end.send(11'h022, 10, 64);
        rd_chk("bad stop", ADDR_CTRL, 8'h70);
        // short pulse rejected, next frame taken
        far_end.send(11'h000, 1, 16);
        far_end.send(11'h2fc, 10, 64);
        rd_chk("after pulse", ADDR_BUF, 8'h7e);
        rd_chk("pulse flags", ADDR_CTRL, 8'h75);
        wr_reg(ADDR_MODE, 8'h00);
        wr_reg(ADDR_CTRL, 8'h40);
        wr_reg(ADDR_BUF, 8'h0f);
        frame_chk("slow frame", 10, 256, 11'h21e);
        // mode 3 with ninth bit set
        wr_reg(ADDR_MODE, 8'h02);
        wr_reg(ADDR_CTRL, 8'hc8);
        wr_reg(ADDR_BUF, 8'h81);
        frame_chk("mode3 frame", 11, 64, 11'h702);
        // mode 2 receive at 32 cycles a bit
        wr_reg(ADDR_CTRL, 8'h90);
        far_end.send(11'h4cc, 11, 32);
        rd_chk("mode2 byte", ADDR_BUF, 8'h66);
        rd_chk("mode2 flags", ADDR_CTRL, 8'h91);
        wr_reg(ADDR_CTRL, 8'h20);
        wr_reg(ADDR_BUF, 8'h96);
        shift_chk(8'h96, 4);
        rd_chk("shift flag", ADDR_CTRL, 8'h22);
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_BUF, 8'h5a);
        shift_chk(8'h5a, 12);
        // shift mode receive at the fast rate
        wr_reg(ADDR_CTRL, 8'h30);
        far_end.feed_shift(8'hc3, ok);
        guard();
        rd_chk("shift rx byte", ADDR_BUF, 8'hc3);
        rd_chk("shift rx flag", ADDR_CTRL, 8'h31);
        close_out();
    end
endmodule // testbench
`default_nettype wire
